/* src/arst_pkg.sv */
package arst_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam longint unsigned PIX_HZ = 64'd20_034_000;
  localparam longint unsigned OUT_HZ = 64'd40_068_000;
  localparam longint unsigned LINE_HI_HZ = 64'd31_500;
  localparam longint unsigned LINE_LO_HZ = 64'd15_750;
  localparam logic [31:0] PIX_INC = 32'((PIX_HZ << 32) / CLK_HZ);
  localparam logic [31:0] OUT_INC = 32'((OUT_HZ << 32) / CLK_HZ);
  localparam logic [31:0] LINE_HI_INC = 32'((LINE_HI_HZ << 32) / CLK_HZ);
  localparam logic [31:0] LINE_LO_INC = 32'((LINE_LO_HZ << 32) / CLK_HZ);

  // ----------------------------------------------------------------
  // dial and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] DIAL_NORMAL = 4'h0;
  localparam logic [3:0] DIAL_FAST_LO = 4'h1;
  localparam logic [3:0] DIAL_FAST_HI = 4'h4;
  localparam logic [3:0] DIAL_SLOW_LO = 4'h5;
  localparam logic [3:0] DIAL_SLOW_HI = 4'h8;
  localparam logic [3:0] DIAL_PULSE = 4'h9;
  localparam logic [3:0] PW_CLEAR_LINE = 4'h9;
  localparam logic [7:0] EXPO_ONE_LINE = 8'h01;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  localparam int CTRL_DIAL_LSB = 0;
  localparam int CTRL_STD_BIT = 4;
  localparam logic [3:0] CTRL_DIAL_RST = 4'h0;
  localparam logic CTRL_STD_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ALIGN = 4'b0010,
    ST_EXPOSE = 4'b0100,
    ST_PW_LOW = 4'b1000
  } arst_state_e;

  typedef struct packed {
    logic valid;
    logic vsync;
    logic [9:0] data;
  } arst_prog_s;

  typedef struct packed {
    logic valid;
    logic field;
    logic [7:0] data;
  } arst_ana_s;

  typedef struct packed {
    logic discharge;
    logic internal_reset;
    logic second_reset_marker;
    logic black;
  } arst_sensor_s;

endpackage

/* src/arst_shutter.sv */
`timescale 1ns/10ps
module arst_shutter #(
  parameter int H_PIX = 1024,
  parameter int V_LINES = 1024
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic async_reset_input_i,
  input wire logic horizontal_drive_i,
  input wire logic [9:0] pix_data_i,
  input wire logic pix_valid_i,
  output arst_pkg::arst_prog_s prog_video_o,
  output arst_pkg::arst_ana_s ana_video_o,
  output arst_pkg::arst_sensor_s sensor_o,
  output logic pix_clk_o,
  output logic out_clk_o,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  localparam int FRAME = H_PIX * V_LINES;
  localparam int AW = $clog2(FRAME);
  localparam int HW = $clog2(H_PIX);
  localparam int VW = $clog2(V_LINES);
  localparam logic [AW-1:0] LAST_ADDR = AW'(FRAME - 1);
  localparam logic [HW-1:0] LAST_PIX = HW'(H_PIX - 1);
  localparam logic [VW-1:0] HALF_LINES = VW'(V_LINES / 2);

  initial
  begin
    if (H_PIX < 2 || V_LINES < 4 || (H_PIX & (H_PIX - 1)) != 0 ||
      (V_LINES & (V_LINES - 1)) != 0)
    begin
      $error("frame size must be powers of two, at least 2 pixels and 4 lines");
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic vr1, vr2, vr3;
    logic hd1, hd2, hd3;
    logic [32:0] pix_acc;
    logic [32:0] out_acc;
    logic [32:0] line_acc;
    arst_pkg::arst_state_e st;
    logic [7:0] line_cnt;
    logic pw_cleared;
    logic cap_active;
    logic [AW-1:0] cap_addr;
    logic frame_valid;
    logic [15:0] cap_count;
    logic [AW-1:0] prog_addr;
    arst_pkg::arst_prog_s prog;
    logic ana_run;
    logic [VW-1:0] ana_delay;
    logic [HW-1:0] ana_pix;
    logic [VW-1:0] ana_line;
    arst_pkg::arst_ana_s ana;
    arst_pkg::arst_sensor_s sens;
    logic [3:0] dial;
    logic std_hi;
    logic aw_ok, w_ok;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } arst_state_s;

  arst_state_s s_q, s_d;
  logic [9:0] frame_mem [FRAME];
  logic mem_we;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic vr_fall, vr_rise, hd_edge, pix_tick, out_tick, line_tick;
    logic async_mode, fast_mode, slow_mode, pw_mode;
    logic restart, aw_take, w_take, ar_take;
    logic [7:0] expo_lines;
    logic [3:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [VW-1:0] ana_row;
    s_d = s_q;
    mem_we = 1'b0;
    // three-stage pin capture, edges found after the second stage
    s_d.vr1 = async_reset_input_i;
    s_d.vr2 = s_q.vr1;
    s_d.vr3 = s_q.vr2;
    s_d.hd1 = horizontal_drive_i;
    s_d.hd2 = s_q.hd1;
    s_d.hd3 = s_q.hd2;
    vr_fall = s_q.vr3 & ~s_q.vr2;
    vr_rise = ~s_q.vr3 & s_q.vr2;
    hd_edge = s_q.hd2 & ~s_q.hd3;
    // phase accumulators for pixel, output and analog line rates
    s_d.pix_acc = {1'b0, s_q.pix_acc[31:0]} + {1'b0, arst_pkg::PIX_INC};
    s_d.out_acc = {1'b0, s_q.out_acc[31:0]} + {1'b0, arst_pkg::OUT_INC};
    s_d.line_acc = {1'b0, s_q.line_acc[31:0]} + {1'b0, s_q.std_hi ?
      arst_pkg::LINE_HI_INC : arst_pkg::LINE_LO_INC};
    pix_tick = s_q.pix_acc[32];
    out_tick = s_q.out_acc[32];
    line_tick = s_q.line_acc[32];
    // mode decode
    fast_mode = (s_q.dial >= arst_pkg::DIAL_FAST_LO) &&
      (s_q.dial <= arst_pkg::DIAL_FAST_HI);
    slow_mode = (s_q.dial >= arst_pkg::DIAL_SLOW_LO) &&
      (s_q.dial <= arst_pkg::DIAL_SLOW_HI);
    pw_mode = (s_q.dial == arst_pkg::DIAL_PULSE);
    async_mode = fast_mode | slow_mode | pw_mode;
    expo_lines = arst_pkg::EXPO_ONE_LINE << (s_q.dial - arst_pkg::DIAL_FAST_LO);
    restart = 1'b0;
    s_d.sens.internal_reset = 1'b0;
    s_d.sens.second_reset_marker = 1'b0;
    s_d.sens.discharge = 1'b0;
    // ----------------------------------------------------------------
    // shutter sequencing
    // ----------------------------------------------------------------
    case (s_q.st)
      arst_pkg::ST_IDLE:
      begin
        if (vr_fall && pw_mode)
        begin
          s_d.st = arst_pkg::ST_PW_LOW;
          s_d.line_cnt = '0;
          s_d.pw_cleared = 1'b0;
        end
        else if (vr_fall && (fast_mode || slow_mode))
        begin
          s_d.st = arst_pkg::ST_ALIGN;
        end
      end
      arst_pkg::ST_ALIGN:
      begin
        if (hd_edge)
        begin
          s_d.sens.internal_reset = 1'b1;
          s_d.sens.discharge = 1'b1;
          s_d.line_cnt = '0;
          if (fast_mode)
          begin
            restart = 1'b1;
            s_d.st = arst_pkg::ST_IDLE;
          end
          else
          begin
            s_d.st = arst_pkg::ST_EXPOSE;
          end
        end
      end
      arst_pkg::ST_EXPOSE:
      begin
        if (hd_edge)
        begin
          s_d.line_cnt = s_q.line_cnt + 8'h01;
          if (s_q.line_cnt + 8'h01 == expo_lines)
          begin
            s_d.sens.internal_reset = 1'b1;
            s_d.sens.second_reset_marker = 1'b1;
            restart = 1'b1;
            s_d.st = arst_pkg::ST_IDLE;
          end
        end
      end
      arst_pkg::ST_PW_LOW:
      begin
        if (hd_edge && !s_q.pw_cleared)
        begin
          s_d.line_cnt = s_q.line_cnt + 8'h01;
          if (s_q.line_cnt[3:0] + 4'h1 == arst_pkg::PW_CLEAR_LINE)
          begin
            s_d.sens.discharge = 1'b1;
            s_d.pw_cleared = 1'b1;
          end
        end
        if (vr_rise)
        begin
          s_d.sens.internal_reset = 1'b1;
          restart = 1'b1;
          s_d.st = arst_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = arst_pkg::ST_IDLE;
      end
    endcase
    if (!async_mode)
    begin
      s_d.st = arst_pkg::ST_IDLE;
    end
    // held high level keeps the sensor clear in an async mode while idle
    if (async_mode && s_q.vr2 && s_q.st == arst_pkg::ST_IDLE)
    begin
      s_d.sens.discharge = 1'b1;
    end
    s_d.sens.black = async_mode && s_q.vr2 && !s_q.frame_valid;
    // ----------------------------------------------------------------
    // capture into frame buffer
    // ----------------------------------------------------------------
    if (restart)
    begin
      s_d.cap_active = 1'b1;
      s_d.cap_addr = '0;
      s_d.prog_addr = '0;
      s_d.ana_run = 1'b0;
      s_d.ana_delay = '0;
    end
    else if (s_q.cap_active && pix_valid_i)
    begin
      mem_we = 1'b1;
      s_d.cap_addr = s_q.cap_addr + 1'b1;
      if (s_q.cap_addr == LAST_ADDR)
      begin
        s_d.cap_active = 1'b0;
        s_d.frame_valid = 1'b1;
        s_d.cap_count = s_q.cap_count + 16'h0001;
      end
    end
    // ----------------------------------------------------------------
    // progressive output
    // ----------------------------------------------------------------
    s_d.prog.valid = 1'b0;
    s_d.prog.vsync = 1'b0;
    if (!async_mode)
    begin
      s_d.prog.valid = pix_valid_i;
      s_d.prog.data = pix_data_i;
    end
    else if (out_tick && !restart)
    begin
      s_d.prog.valid = 1'b1;
      s_d.prog.vsync = (s_q.prog_addr == '0);
      s_d.prog.data = s_q.sens.black ? 10'h000 : frame_mem[s_q.prog_addr];
      s_d.prog_addr = (s_q.prog_addr == LAST_ADDR) ? '0 : s_q.prog_addr + 1'b1;
    end
    // ----------------------------------------------------------------
    // interlaced analog output, one field behind
    // ----------------------------------------------------------------
    s_d.ana.valid = 1'b0;
    ana_row = {s_q.ana_line[VW-2:0], s_q.ana.field};
    if (!s_q.ana_run && !restart && line_tick)
    begin
      s_d.ana_delay = s_q.ana_delay + 1'b1;
      if (s_q.ana_delay + 1'b1 == HALF_LINES)
      begin
        s_d.ana_run = 1'b1;
        s_d.ana_line = '0;
        s_d.ana_pix = '0;
        s_d.ana.field = 1'b0;
      end
    end
    else if (s_q.ana_run)
    begin
      if (line_tick)
      begin
        s_d.ana_pix = '0;
        s_d.ana_line = s_q.ana_line + 1'b1;
        if (s_q.ana_line + 1'b1 == HALF_LINES)
        begin
          s_d.ana_line = '0;
          s_d.ana.field = ~s_q.ana.field;
        end
      end
      else if (pix_tick && s_q.ana_pix != LAST_PIX)
      begin
        s_d.ana.valid = 1'b1;
        s_d.ana.data = s_q.sens.black ? 8'h00 :
          frame_mem[AW'({ana_row, s_q.ana_pix})][9:2];
        s_d.ana_pix = s_q.ana_pix + 1'b1;
      end
    end
    // ----------------------------------------------------------------
    // register slave
    // ----------------------------------------------------------------
    aw_take = s_axi_awvalid && !s_q.aw_ok && !s_q.bvalid;
    w_take = s_axi_wvalid && !s_q.w_ok && !s_q.bvalid;
    ar_take = s_axi_arvalid && !s_q.rvalid;
    if (aw_take)
    begin
      s_d.aw_ok = 1'b1;
      s_d.aw_addr = s_axi_awaddr[3:0];
    end
    if (w_take)
    begin
      s_d.w_ok = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    wa = aw_take ? s_axi_awaddr[3:0] : s_q.aw_addr;
    wd = w_take ? s_axi_wdata : s_q.w_data;
    ws = w_take ? s_axi_wstrb : s_q.w_strb;
    if ((aw_take || s_q.aw_ok) && (w_take || s_q.w_ok))
    begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = arst_pkg::RESP_SLVERR;
      if (wa == arst_pkg::OFS_CTRL)
      begin
        s_d.bresp = arst_pkg::RESP_OKAY;
        if (ws[0])
        begin
          s_d.dial = wd[arst_pkg::CTRL_DIAL_LSB +: 4];
          s_d.std_hi = wd[arst_pkg::CTRL_STD_BIT];
        end
      end
      else if (wa == arst_pkg::OFS_STATUS || wa == arst_pkg::OFS_COUNT)
      begin
        s_d.bresp = arst_pkg::RESP_OKAY;
      end
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = arst_pkg::RESP_OKAY;
      s_d.rdata = '0;
      case (s_axi_araddr[3:0])
        arst_pkg::OFS_CTRL:
        begin
          s_d.rdata[arst_pkg::CTRL_DIAL_LSB +: 4] = s_q.dial;
          s_d.rdata[arst_pkg::CTRL_STD_BIT] = s_q.std_hi;
        end
        arst_pkg::OFS_STATUS:
        begin
          s_d.rdata[3:0] = s_q.st;
          s_d.rdata[4] = s_q.frame_valid;
          s_d.rdata[5] = s_q.cap_active;
          s_d.rdata[6] = s_q.ana.field;
          s_d.rdata[7] = s_q.vr2;
        end
        arst_pkg::OFS_COUNT:
        begin
          s_d.rdata[15:0] = s_q.cap_count;
        end
        default:
        begin
          s_d.rresp = arst_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.st <= arst_pkg::ST_IDLE;
      s_q.dial <= arst_pkg::CTRL_DIAL_RST;
      s_q.std_hi <= arst_pkg::CTRL_STD_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (mem_we)
    begin
      frame_mem[s_q.cap_addr] <= pix_data_i;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prog_video_o = s_q.prog;
  assign ana_video_o = s_q.ana;
  assign sensor_o = s_q.sens;
  assign pix_clk_o = s_q.pix_acc[31];
  assign out_clk_o = s_q.out_acc[31];
  assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_ok && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

endmodule // arst_shutter

/* tb/arst_far_end.sv */
`timescale 1ns/10ps
module arst_far_end (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [7:0] width_i,
  output logic async_reset_input_o,
  output logic horizontal_drive_o,
  output logic [9:0] pix_data_o,
  output logic pix_valid_o
);
  logic [7:0] left = 8'h00;
  logic [1:0] ph = 2'h0;
  logic [9:0] cnt = 10'h000;
  // ----------------------------------------------------------------
  // line drive and trigger pulse
  // ----------------------------------------------------------------
  initial
  begin
    async_reset_input_o = 1'b1;
    horizontal_drive_o = 1'b0;
    #3;
    forever #40 horizontal_drive_o = ~horizontal_drive_o;
  end
  // pulse goes low mid-line and lasts width_i lines
  always @(negedge horizontal_drive_o)
  begin
    if (left != 8'h00)
    begin
      left <= left - 8'h01;
      if (left == 8'h01)
        async_reset_input_o <= 1'b1;
    end
    else if (go_i && async_reset_input_o)
    begin
      async_reset_input_o <= 1'b0;
      left <= width_i;
    end
  end
  // ----------------------------------------------------------------
  // pixel stream, data toggles between words
  // ----------------------------------------------------------------
  initial
  begin
    pix_data_o = 10'h000;
    pix_valid_o = 1'b0;
  end
  always @(posedge mclk_i)
  begin
    ph <= ph + 2'h1;
    pix_valid_o <= (ph == 2'h0);
    pix_data_o <= (ph == 2'h0) ? cnt : ~cnt;
    if (ph == 2'h0)
      cnt <= cnt + 10'h001;
  end
endmodule // arst_far_end

/* tb/arst_shutter_sva.sv */
`timescale 1ns/10ps
module arst_shutter_sva (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire arst_pkg::arst_prog_s prog_video_o,
  input wire arst_pkg::arst_sensor_s sensor_o,
  input wire logic pix_clk_o,
  input wire logic out_clk_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  chk_reset_pulse: assert property (sensor_o.internal_reset |=> !sensor_o.internal_reset)
    else $error("internal reset longer than one cycle");
  chk_marker_reset: assert property (sensor_o.second_reset_marker |-> sensor_o.internal_reset)
    else $error("marker without internal reset");
  chk_vsync_word: assert property (prog_video_o.vsync |-> prog_video_o.valid)
    else $error("frame start without word");
  chk_pix_rate: assert property ($rose(pix_clk_o) |-> ##[2:3] !pix_clk_o)
    else $error("pixel clock high too long");
  chk_out_rate: assert property ($rose(out_clk_o) |-> ##[1:2] !out_clk_o)
    else $error("output clock high too long");
endmodule // arst_shutter_sva

/* tb/arst_shutter_tb_top.sv */
`timescale 1ns/10ps
module arst_shutter_tb_top;
  localparam int FRAME = 64;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic [7:0] width = 8'h02;
  logic async_reset_input_i;
  logic horizontal_drive_i;
  logic [9:0] pix_data_i;
  logic pix_valid_i;
  arst_pkg::arst_prog_s prog_video_o;
  arst_pkg::arst_ana_s ana_video_o;
  arst_pkg::arst_sensor_s sensor_o;
  logic pix_clk_o;
  logic out_clk_o;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic hd_q = 1'b0;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int hd_cnt = 0;
  int exp_cnt = 0;
  logic [9:0] frame_v0 = 10'h000;

  arst_shutter #(.H_PIX(8), .V_LINES(8)) dut (.mclk_i, .rst_i, .async_reset_input_i,
    .horizontal_drive_i, .pix_data_i, .pix_valid_i, .prog_video_o, .ana_video_o, .sensor_o,
    .pix_clk_o, .out_clk_o, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);
  arst_far_end far (.mclk_i, .go_i(go), .width_i(width),
    .async_reset_input_o(async_reset_input_i), .horizontal_drive_o(horizontal_drive_i),
    .pix_data_o(pix_data_i), .pix_valid_o(pix_valid_i));

  // ----------------------------------------------------------------
  // clock, line counter, timeout
  // ----------------------------------------------------------------
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    hd_q <= horizontal_drive_i;
    if (horizontal_drive_i && !hd_q)
      hd_cnt <= hd_cnt + 1;
    if (cyc == 30000)
    begin
      miscompares = miscompares + 1;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= {28'h0, a};
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {28'h0, a};
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic set_dial(input logic [3:0] dial);
    logic [1:0] r;
    axi_wr(arst_pkg::OFS_CTRL, {27'h0, 1'b1, dial}, r);
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic fire(input logic [7:0] w, output int n0);
    width <= w;
    go <= 1'b1;
    @(posedge mclk_i);
    while (async_reset_input_i) @(posedge mclk_i);
    n0 = hd_cnt;
    go <= 1'b0;
  endtask
  task automatic check_frame();
    logic [31:0] c;
    logic [1:0] r;
    logic [9:0] v0;
    int k;
    exp_cnt++;
    do axi_rd(arst_pkg::OFS_COUNT, c, r); while (c[15:0] !== exp_cnt[15:0]);
    do @(posedge mclk_i); while (prog_video_o.vsync !== 1'b1);
    v0 = prog_video_o.data;
    frame_v0 = v0;
    k = 1;
    while (k < FRAME)
    begin
      @(posedge mclk_i);
      if (prog_video_o.valid === 1'b1)
      begin
        check("word", prog_video_o.data, 10'(v0 + k[9:0]));
        k++;
      end
    end
    do @(posedge mclk_i); while (prog_video_o.vsync !== 1'b1);
    check("repeat", prog_video_o.data, v0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_live();
    logic [9:0] sav;
    int nv;
    nv = 0;
    sav = 10'h000;
    repeat (60)
    begin
      @(posedge mclk_i);
      if (prog_video_o.valid === 1'b1)
      begin
        check("live", prog_video_o.data, sav);
        nv++;
      end
      if (pix_valid_i)
        sav = pix_data_i;
    end
    check("live words", nv > 0, 1);
    $display("test live done");
  endtask
  task automatic test_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(arst_pkg::OFS_CTRL, d, r);
    check("ctrl reset", d, 32'h10);
    axi_rd(arst_pkg::OFS_STATUS, d, r);
    check("state idle", d[3:0], 4'h1);
    axi_wr(arst_pkg::OFS_CTRL, 32'h19, r);
    axi_rd(arst_pkg::OFS_CTRL, d, r);
    check("ctrl dial", d[4:0], 5'h19);
    axi_wr(4'hc, 32'h5, r);
    check("wr resp", r, arst_pkg::RESP_SLVERR);
    axi_rd(4'hc, d, r);
    check("rd data", d, 32'h0);
    check("rd resp", r, arst_pkg::RESP_SLVERR);
    axi_wr(arst_pkg::OFS_STATUS, 32'hff, r);
    check("ro resp", r, arst_pkg::RESP_OKAY);
    set_dial(arst_pkg::DIAL_NORMAL);
    $display("test regs done");
  endtask
  task automatic test_seq(input logic [3:0] dial);
    int n0;
    set_dial(dial);
    check("hold clear", sensor_o.discharge, 1);
    check("hold black", sensor_o.black, exp_cnt == 0);
    do @(posedge mclk_i); while (prog_video_o.valid !== 1'b1);
    if (exp_cnt == 0)
      check("black word", prog_video_o.data, 10'h000);
    fire(8'h02, n0);
    while (sensor_o.internal_reset !== 1'b1) @(posedge mclk_i);
    check("align lines", hd_cnt - n0, 1);
    check("align clear", sensor_o.discharge, 1);
    n0 = hd_cnt;
    if (dial >= arst_pkg::DIAL_SLOW_LO)
    begin
      do @(posedge mclk_i); while (sensor_o.second_reset_marker !== 1'b1);
      check("second lines", hd_cnt - n0, 1 << (dial - 1));
      check("second reset", sensor_o.internal_reset, 1);
    end
    check_frame();
    $display("test dial %0d done", dial);
  endtask
  task automatic test_pulse();
    int n0;
    int k;
    set_dial(arst_pkg::DIAL_PULSE);
    fire(8'h0c, n0);
    repeat (4) @(posedge mclk_i);
    while (sensor_o.discharge !== 1'b1) @(posedge mclk_i);
    check("clear lines", hd_cnt - n0, 9);
    while (!async_reset_input_i) @(posedge mclk_i);
    k = 0;
    while (sensor_o.internal_reset !== 1'b1 && k < 8)
    begin
      @(posedge mclk_i);
      k++;
    end
    check("rise reset", sensor_o.internal_reset, 1);
    check_frame();
    $display("test pulse done");
  endtask
  task automatic test_analog();
    logic [9:0] w;
    int k;
    k = 0;
    while (k < 7)
    begin
      @(posedge mclk_i);
      if (ana_video_o.valid === 1'b1)
      begin
        w = frame_v0 + k[9:0];
        check("ana field", ana_video_o.field, 1'b0);
        check("ana word", ana_video_o.data, w[9:2]);
        k++;
      end
    end
    $display("test analog done");
  endtask

  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    test_live();
    test_regs();
    test_seq(arst_pkg::DIAL_FAST_LO);
    test_seq(arst_pkg::DIAL_FAST_HI);
    test_seq(arst_pkg::DIAL_SLOW_LO);
    test_seq(arst_pkg::DIAL_SLOW_HI);
    test_pulse();
    test_analog();
    conclude();
  end
endmodule // arst_shutter_tb_top

bind arst_shutter arst_shutter_sva chk (.mclk_i, .rst_i, .prog_video_o, .sensor_o, .pix_clk_o,
  .out_clk_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata);
